/* File: hw/packed_shift_subtract_unit.sv */
// Packed shift and subtract execution unit with its register bank
`timescale 1ns/100ps
`default_nettype none
`include "pssu_defines.svh"
module packed_shift_subtract_unit import pssu_pkg::*; #(
	parameter int REG_COUNT = 8,
	parameter int DATA_W = 64
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic issue_valid,
	input wire logic [15:0] opcode,
	input wire logic [7:0] modrm,
	input wire logic [7:0] imm_byte,
	input wire logic [63:0] mem_data,
	input wire logic load_valid,
	input wire logic [2:0] load_index,
	input wire logic [63:0] load_data,
	output logic result_valid,
	output logic [2:0] result_index,
	output logic [63:0] result_data,
	output logic fault
);
	// Width checks
	if (REG_COUNT != 8 || DATA_W != 64) begin : g_bad_param
		$error("packed unit needs eight 64-bit registers");
	end

	exec_if ex (.clk(clk), .rst_n(rst_n));

	qword_t regs_reg [REG_COUNT];
	qword_t regs_next [REG_COUNT];
	logic result_valid_reg;
	logic result_valid_next;
	logic [2:0] result_index_reg;
	logic [2:0] result_index_next;
	qword_t result_data_reg;
	qword_t result_data_next;
	logic fault_reg;
	logic fault_next;

	op_t op;
	logic legal;
	logic is_shift;
	logic imm_form;
	logic reg_form;
	logic [2:0] dest_idx;
	qword_t src_val;
	qword_t result;

	// Operand form from the mod field
	assign reg_form = modrm[`MODRM_MOD] == `MOD_REG_FORM;

	// Opcode decode
	always_comb begin
		op = op_none;
		imm_form = 1'b0;
		unique case (opcode)
			`OPC_WORD_ARS: op = op_word_ars; // RL1
			`OPC_DWORD_LRS: op = op_dword_lrs; // RL2
			`OPC_QWORD_LRS: op = op_qword_lrs; // RL3
			`OPC_WORD_LRS: op = op_word_lrs; // RL4
			`OPC_BYTE_WSUB: op = op_byte_wsub; // RL8
			`OPC_DWORD_WSUB: op = op_dword_wsub; // RL9
			`OPC_SBYTE_SSUB: op = op_sbyte_ssub; // RL10
			`OPC_SWORD_SSUB: op = op_sword_ssub; // RL11
			`OPC_UBYTE_SSUB: op = op_ubyte_ssub; // RL12
			`OPC_UWORD_SSUB: op = op_uword_ssub; // RL13
			`OPC_IMM_WORD: begin
				imm_form = 1'b1;
				if (reg_form && modrm[`MODRM_REG] == `GRP_ARITH_RIGHT) begin
					op = op_word_ars; // RL7
				end else if (reg_form &&
					modrm[`MODRM_REG] == `GRP_LOGIC_RIGHT) begin
					op = op_word_lrs; // RL7
				end
			end
			`OPC_IMM_DWORD: begin
				imm_form = 1'b1;
				if (reg_form && modrm[`MODRM_REG] == `GRP_LOGIC_RIGHT) begin
					op = op_dword_lrs; // RL7
				end
			end
			`OPC_IMM_QWORD: begin
				imm_form = 1'b1;
				if (reg_form && modrm[`MODRM_REG] == `GRP_LOGIC_RIGHT) begin
					op = op_qword_lrs; // RL7
				end
			end
			default: op = op_none;
		endcase
	end

	assign legal = op != op_none;
	assign is_shift = op == op_word_ars || op == op_word_lrs ||
		op == op_dword_lrs || op == op_qword_lrs;

	// Operand and target selection
	always_comb begin
		if (imm_form) begin
			dest_idx = modrm[`MODRM_RM]; // RL7
			src_val = {56'h0, imm_byte}; // RL7
		end else if (reg_form) begin
			dest_idx = modrm[`MODRM_REG]; // RL5 RL14
			src_val = regs_reg[modrm[`MODRM_RM]]; // RL5 RL14
		end else begin
			dest_idx = modrm[`MODRM_REG]; // RL6 RL15
			src_val = mem_data; // RL6 RL15
		end
	end

	// Lane units
	assign ex.op = op;
	assign ex.dst_val = regs_reg[dest_idx];
	assign ex.src_val = src_val;

	lane_shifter u_shift (.bus(ex.shifter));
	lane_subtractor u_sub (.bus(ex.subber));

	assign result = is_shift ? ex.shift_res : ex.sub_res;

	// Register bank and result next values; issue beats load
	always_comb begin
		for (int r = 0; r < REG_COUNT; r++) begin
			regs_next[r] = regs_reg[r];
		end
		if (load_valid) begin
			regs_next[load_index] = load_data;
		end
		result_valid_next = 1'b0;
		result_index_next = result_index_reg;
		result_data_next = result_data_reg;
		fault_next = 1'b0;
		if (issue_valid && legal) begin
			regs_next[dest_idx] = result; // RL16
			result_valid_next = 1'b1; // RL16
			result_index_next = dest_idx;
			result_data_next = result;
		end else if (issue_valid) begin
			fault_next = 1'b1;
		end
	end

	// State registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int r = 0; r < REG_COUNT; r++) begin
				regs_reg[r] <= `QWORD_ZERO;
			end
			result_valid_reg <= 1'b0;
			result_index_reg <= 3'h0;
			result_data_reg <= `QWORD_ZERO;
			fault_reg <= 1'b0;
		end else begin
			regs_reg <= regs_next;
			result_valid_reg <= result_valid_next;
			result_index_reg <= result_index_next;
			result_data_reg <= result_data_next;
			fault_reg <= fault_next;
		end
	end

	assign result_valid = result_valid_reg;
	assign result_index = result_index_reg;
	assign result_data = result_data_reg;
	assign fault = fault_reg;

	// Issue steps used by the checks
	sequence s_issue_legal;
		issue_valid && legal;
	endsequence

	sequence s_reg_shift;
		issue_valid && legal && is_shift && reg_form && !imm_form;
	endsequence

	sequence s_mem_sub;
		issue_valid && legal && !is_shift && !reg_form;
	endsequence

	a_one_clock: assert property (@(posedge clk) disable iff (!rst_n) // RL16
		s_issue_legal |=> result_valid)
		else $error("result not one clock after issue");
	a_back_to_back: assert property (@(posedge clk) // RL16
		disable iff (!rst_n)
		s_issue_legal ##1 s_issue_legal |=> result_valid ##0
		$past(result_valid))
		else $error("back to back issue dropped");
	a_reg_count: assert property (@(posedge clk) disable iff (!rst_n) // RL5
		s_reg_shift |=> result_index == $past(modrm[5:3]))
		else $error("register shift target wrong");
	a_mem_target: assert property (@(posedge clk) disable iff (!rst_n) // RL15
		s_mem_sub |=> result_index == $past(modrm[5:3]) &&
		result_data == $past(ex.sub_res))
		else $error("memory subtract target wrong");
	a_imm_target: assert property (@(posedge clk) disable iff (!rst_n) // RL7
		issue_valid && legal && imm_form |=>
		result_index == $past(modrm[2:0]))
		else $error("immediate shift target wrong");
	a_mem_count: assert property (@(posedge clk) disable iff (!rst_n) // RL6
		issue_valid && legal && is_shift && !reg_form |->
		ex.src_val == mem_data)
		else $error("memory count not used");
	a_write_back: assert property (@(posedge clk) // RL14
		disable iff (!rst_n)
		s_issue_legal ##1 !load_valid[*1] |->
		regs_reg[result_index] == result_data)
		else $error("register bank not written");
	a_bad_op_fault: assert property (@(posedge clk) // RL7
		disable iff (!rst_n)
		issue_valid && !legal |=> fault && !result_valid)
		else $error("illegal opcode not refused");
	a_qword_shift: assert property (@(posedge clk) // RL3
		disable iff (!rst_n)
		issue_valid && op == op_qword_lrs && src_val < 64'd64 |=>
		result_data == $past(ex.dst_val) >> $past(src_val[5:0]))
		else $error("qword shift wrong");
	a_dword_sub: assert property (@(posedge clk) // RL9
		disable iff (!rst_n)
		issue_valid && op == op_dword_wsub |=>
		result_data[63:32] ==
		32'($past(ex.dst_val[63:32]) - $past(src_val[63:32])))
		else $error("dword subtract wrong");
	a_word_lrs: assert property (@(posedge clk) // RL4
		disable iff (!rst_n)
		issue_valid && op == op_word_lrs && src_val > 64'd15 |=>
		result_data == 64'h0)
		else $error("oversized word shift not zero");
	a_word_ars: assert property (@(posedge clk) // RL1
		disable iff (!rst_n)
		issue_valid && op == op_word_ars && src_val == 64'd1 |=>
		result_data[15:0] ==
		{$past(ex.dst_val[15]), $past(ex.dst_val[15:1])})
		else $error("word arithmetic shift wrong");
	a_sbyte_sat: assert property (@(posedge clk) // RL10
		disable iff (!rst_n)
		issue_valid && op == op_sbyte_ssub &&
		ex.dst_val[7:0] == 8'h7F && src_val[7:0] == 8'hFF |=>
		result_data[7:0] == 8'h7F)
		else $error("signed byte subtract not clamped");
	a_uword_sat: assert property (@(posedge clk) // RL13
		disable iff (!rst_n)
		issue_valid && op == op_uword_ssub &&
		ex.dst_val[15:0] < src_val[15:0] |=> result_data[15:0] == 16'h0)
		else $error("unsigned word subtract not clamped");

	// Bank load, result hold and register source steps
	sequence s_plain_load;
		load_valid &&
		!(issue_valid && legal && dest_idx == load_index);
	endsequence

	sequence s_no_result;
		!(issue_valid && legal);
	endsequence

	sequence s_reg_source;
		issue_valid && legal && reg_form && !imm_form;
	endsequence

	a_load_lands: assert property (@(posedge clk) // RL14
		disable iff (!rst_n)
		s_plain_load |=>
		regs_reg[$past(load_index)] == $past(load_data))
		else $error("bank load lost");
	a_hold_result: assert property (@(posedge clk) // RL16
		disable iff (!rst_n)
		s_no_result |=> $stable(result_data) && $stable(result_index))
		else $error("result changed without issue");
	a_idle_quiet: assert property (@(posedge clk) // RL16
		disable iff (!rst_n)
		!issue_valid |=> !result_valid && !fault)
		else $error("result or fault without issue");
	a_valid_or_fault: assert property (@(posedge clk) // RL7
		disable iff (!rst_n)
		!(result_valid && fault))
		else $error("result and fault together");
	a_fault_cause: assert property (@(posedge clk) // RL7
		disable iff (!rst_n)
		fault |-> $past(issue_valid) && !$past(legal))
		else $error("fault without refused issue");

	// Operand source checks
	a_reg_source: assert property (@(posedge clk) // RL14
		disable iff (!rst_n)
		s_reg_source |-> ex.src_val == regs_reg[modrm[`MODRM_RM]])
		else $error("register source not taken from r/m");
	a_imm_count: assert property (@(posedge clk) // RL7
		disable iff (!rst_n)
		issue_valid && legal && imm_form |->
		ex.src_val == {56'h0, imm_byte})
		else $error("immediate count not used");
	a_mem_source: assert property (@(posedge clk) // RL15
		disable iff (!rst_n)
		s_mem_sub |-> ex.src_val == mem_data)
		else $error("memory subtrahend not used");

	// Lane result checks
	a_dword_lrs: assert property (@(posedge clk) // RL2
		disable iff (!rst_n)
		issue_valid && op == op_dword_lrs && src_val < 64'd32 |=>
		result_data[31:0] ==
		$past(ex.dst_val[31:0]) >> $past(src_val[`DWORD_CNT_LO]))
		else $error("dword logical shift wrong");
	a_word_lrs_one: assert property (@(posedge clk) // RL4
		disable iff (!rst_n)
		issue_valid && op == op_word_lrs && src_val == 64'd1 |=>
		result_data[15:0] == {1'b0, $past(ex.dst_val[15:1])})
		else $error("word logical shift by one wrong");
	a_ubyte_sub: assert property (@(posedge clk) // RL12
		disable iff (!rst_n)
		issue_valid && op == op_ubyte_ssub &&
		ex.dst_val[7:0] >= src_val[7:0] |=> result_data[7:0] ==
		8'($past(ex.dst_val[7:0]) - $past(src_val[7:0])))
		else $error("unsigned byte subtract wrong");
endmodule
`default_nettype wire

/* File: shared/pssu_defines.svh */
// Constants of the packed shift and subtract datapath
// Operation
// RL1: Word arithmetic right shift keeps lane sign
// RL2: Dword logical right shift fills zeros
// RL3: Qword logical right shift fills zeros
// RL4: Word logical right shift fills zeros
// RL5: Register count: second register, result first
// RL6: Memory count: memory operand, reg field target
// RL7: Immediate count byte; reg selects, r/m target
// RL8: Byte subtract keeps low eight bits
// RL9: Dword subtract modulo two to thirty-two
// RL10: Signed byte subtract clamps to byte range
// RL11: Signed word subtract clamps to word range
// RL12: Unsigned byte subtract clamps negatives to zero
// RL13: Unsigned word subtract clamps underflow to zero
// RL14: Register subtract: second subtrahend, first destination
// RL15: Memory subtract: memory subtrahend, reg field target
// RL16: One clock latency, one per clock
// RL17: Oversized counts give zero or sign fill
`ifndef PSSU_DEFINES_SVH
`define PSSU_DEFINES_SVH
`define OPC_WORD_ARS 16'h0FE1
`define OPC_DWORD_LRS 16'h0FD2
`define OPC_QWORD_LRS 16'h0FD3
`define OPC_WORD_LRS 16'h0FD1
`define OPC_BYTE_WSUB 16'h0FF8
`define OPC_DWORD_WSUB 16'h0FFA
`define OPC_SBYTE_SSUB 16'h0FE8
`define OPC_SWORD_SSUB 16'h0FE9
`define OPC_UBYTE_SSUB 16'h0FD8
`define OPC_UWORD_SSUB 16'h0FD9
`define OPC_IMM_WORD 16'h0F71
`define OPC_IMM_DWORD 16'h0F72
`define OPC_IMM_QWORD 16'h0F73
`define GRP_ARITH_RIGHT 3'h4
`define GRP_LOGIC_RIGHT 3'h2
`define MOD_REG_FORM 2'h3
`define MODRM_MOD 7:6
`define MODRM_REG 5:3
`define MODRM_RM 2:0
`define WORD_CNT_LO 3:0
`define WORD_CNT_HI 63:4
`define DWORD_CNT_LO 4:0
`define DWORD_CNT_HI 63:5
`define QWORD_CNT_LO 5:0
`define QWORD_CNT_HI 63:6
`define SBYTE_MAX 8'h7F
`define SBYTE_MIN 8'h80
`define SWORD_MAX 16'h7FFF
`define SWORD_MIN 16'h8000
`define QWORD_ZERO 64'h0000_0000_0000_0000
`endif

/* File: shared/pssu_pkg.sv */
// Types shared by the packed shift and subtract datapath
package pssu_pkg;
	typedef enum logic [3:0] {
		op_none = 4'b0000,
		op_word_ars = 4'b0001,
		op_dword_lrs = 4'b0010,
		op_qword_lrs = 4'b0011,
		op_word_lrs = 4'b0100,
		op_byte_wsub = 4'b0101,
		op_dword_wsub = 4'b0110,
		op_sbyte_ssub = 4'b0111,
		op_sword_ssub = 4'b1000,
		op_ubyte_ssub = 4'b1001,
		op_uword_ssub = 4'b1010
	} op_t;
	typedef logic [63:0] qword_t;
endpackage

/* File: shared/exec_if.sv */
// Operand and result carrier between decode and the lane units
`timescale 1ns/100ps
`default_nettype none
interface exec_if (
	input wire logic clk,
	input wire logic rst_n
);
	import pssu_pkg::*;
	op_t op;
	qword_t dst_val;
	qword_t src_val;
	qword_t shift_res;
	qword_t sub_res;
	modport core (input clk, input rst_n, output op, output dst_val,
		output src_val, input shift_res, input sub_res);
	modport shifter (input clk, input rst_n, input op, input dst_val,
		input src_val, output shift_res);
	modport subber (input clk, input rst_n, input op, input dst_val,
		input src_val, output sub_res);
endinterface
`default_nettype wire

/* File: hw/lane_shifter.sv */
// Right shifts on word, dword and qword lanes
`timescale 1ns/100ps
`default_nettype none
`include "pssu_defines.svh"
module lane_shifter import pssu_pkg::*; (
	exec_if.shifter bus
);
	logic word_big;
	logic dword_big;
	logic qword_big;
	logic [63:0] ars_w;
	logic [63:0] lrs_w;
	logic [63:0] lrs_d;
	logic [63:0] lrs_q;
	logic [63:0] res;

	// Counts past the lane width
	assign word_big = |bus.src_val[`WORD_CNT_HI]; // RL17
	assign dword_big = |bus.src_val[`DWORD_CNT_HI]; // RL17
	assign qword_big = |bus.src_val[`QWORD_CNT_HI]; // RL17
	assign lrs_q = qword_big ? `QWORD_ZERO :
		bus.dst_val >> bus.src_val[`QWORD_CNT_LO]; // RL3

	// Per-lane word and dword shifters
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_word
			logic [15:0] ln;
			assign ln = bus.dst_val[i*16 +: 16];
			assign ars_w[i*16 +: 16] = word_big ? {16{ln[15]}} :
				16'($signed(ln) >>> bus.src_val[`WORD_CNT_LO]); // RL1
			assign lrs_w[i*16 +: 16] = word_big ? 16'h0000 :
				ln >> bus.src_val[`WORD_CNT_LO]; // RL4
		end
		for (i = 0; i < 2; i++) begin : g_dword
			assign lrs_d[i*32 +: 32] = dword_big ? 32'h0000_0000 :
				bus.dst_val[i*32 +: 32] >> bus.src_val[`DWORD_CNT_LO]; // RL2
		end
	endgenerate

	// Result select
	always_comb begin
		unique case (bus.op)
			op_word_ars: res = ars_w;
			op_word_lrs: res = lrs_w;
			op_dword_lrs: res = lrs_d;
			op_qword_lrs: res = lrs_q;
			default: res = `QWORD_ZERO;
		endcase
	end
	assign bus.shift_res = res;

	a_word_signfill: assert property (@(posedge bus.clk) // RL17
		disable iff (!bus.rst_n)
		bus.op == op_word_ars && word_big |->
		bus.shift_res[15:0] == {16{bus.dst_val[15]}})
		else $error("word arithmetic shift lost sign fill");
	a_dword_zero: assert property (@(posedge bus.clk) // RL2
		disable iff (!bus.rst_n)
		bus.op == op_dword_lrs && dword_big |-> bus.shift_res == 64'h0)
		else $error("oversized dword shift not zero");
endmodule
`default_nettype wire

/* File: hw/lane_subtractor.sv */
// Wrap-around and saturating lane subtractions
`timescale 1ns/100ps
`default_nettype none
`include "pssu_defines.svh"
module lane_subtractor import pssu_pkg::*; (
	exec_if.subber bus
);
	logic [63:0] wb;
	logic [63:0] sb;
	logic [63:0] ub;
	logic [63:0] sw;
	logic [63:0] uw;
	logic [63:0] wd;
	logic [63:0] res;

	genvar i;
	generate
		// Byte lanes
		for (i = 0; i < 8; i++) begin : g_byte
			logic [8:0] ud;
			logic [8:0] sd;
			logic [7:0] a;
			logic [7:0] b;
			assign a = bus.dst_val[i*8 +: 8];
			assign b = bus.src_val[i*8 +: 8];
			assign ud = {1'b0, a} - {1'b0, b};
			assign sd = {a[7], a} - {b[7], b};
			assign wb[i*8 +: 8] = ud[7:0]; // RL8
			assign ub[i*8 +: 8] = ud[8] ? 8'h00 : ud[7:0]; // RL12
			assign sb[i*8 +: 8] = (sd[8] == sd[7]) ? sd[7:0] :
				(sd[8] ? `SBYTE_MIN : `SBYTE_MAX); // RL10
		end
		// Word lanes
		for (i = 0; i < 4; i++) begin : g_word
			logic [16:0] ud;
			logic [16:0] sd;
			logic [15:0] a;
			logic [15:0] b;
			assign a = bus.dst_val[i*16 +: 16];
			assign b = bus.src_val[i*16 +: 16];
			assign ud = {1'b0, a} - {1'b0, b};
			assign sd = {a[15], a} - {b[15], b};
			assign uw[i*16 +: 16] = ud[16] ? 16'h0000 : ud[15:0]; // RL13
			assign sw[i*16 +: 16] = (sd[16] == sd[15]) ? sd[15:0] :
				(sd[16] ? `SWORD_MIN : `SWORD_MAX); // RL11
		end
		// Dword lanes
		for (i = 0; i < 2; i++) begin : g_dword
			assign wd[i*32 +: 32] = bus.dst_val[i*32 +: 32] -
				bus.src_val[i*32 +: 32]; // RL9
		end
	endgenerate

	// Result select
	always_comb begin
		unique case (bus.op)
			op_byte_wsub: res = wb;
			op_dword_wsub: res = wd;
			op_sbyte_ssub: res = sb;
			op_sword_ssub: res = sw;
			op_ubyte_ssub: res = ub;
			op_uword_ssub: res = uw;
			default: res = `QWORD_ZERO;
		endcase
	end
	assign bus.sub_res = res;

	a_ubyte_floor: assert property (@(posedge bus.clk) // RL12
		disable iff (!bus.rst_n)
		bus.op == op_ubyte_ssub && bus.dst_val[7:0] < bus.src_val[7:0]
		|-> bus.sub_res[7:0] == 8'h00)
		else $error("unsigned byte subtract not clamped");
	a_sword_clamp: assert property (@(posedge bus.clk) // RL11
		disable iff (!bus.rst_n)
		bus.op == op_sword_ssub && bus.dst_val[15:0] == 16'h8000 &&
		bus.src_val[15:0] == 16'h0001 |-> bus.sub_res[15:0] == 16'h8000)
		else $error("signed word subtract not clamped");
	a_byte_wrap: assert property (@(posedge bus.clk) // RL8
		disable iff (!bus.rst_n)
		bus.op == op_byte_wsub |-> bus.sub_res[15:8] ==
		8'(bus.dst_val[15:8] - bus.src_val[15:8]))
		else $error("byte wrap subtract wrong");
endmodule
`default_nettype wire

/* File: tb/decode_model.sv */
// Behavioural decode stage that feeds the execution unit
`timescale 1ns/100ps
`default_nettype none
module decode_model (
	input wire logic clk,
	output var logic issue_valid,
	output var logic [15:0] opcode,
	output var logic [7:0] modrm,
	output var logic [7:0] imm_byte,
	output var logic [63:0] mem_data,
	output var logic load_valid,
	output var logic [2:0] load_index,
	output var logic [63:0] load_data
);
	// Quiet pins at time zero
	initial begin
		issue_valid = 1'b0;
		opcode = 16'h0000;
		modrm = 8'h00;
		imm_byte = 8'h00;
		mem_data = 64'h0;
		load_valid = 1'b0;
		load_index = 3'h0;
		load_data = 64'h0;
	end

	// One instruction, held until the next call
	task send(input logic [15:0] op, input logic [7:0] mr,
		input logic [7:0] im, input logic [63:0] md);
		issue_valid = 1'b1;
		load_valid = 1'b0;
		opcode = op;
		modrm = mr;
		imm_byte = im;
		mem_data = md;
	endtask

	// Stale operand fields scrambled so nothing leans on them
	task idle();
		issue_valid = 1'b0;
		mem_data = ~mem_data;
		imm_byte = ~imm_byte;
	endtask

	// Bank load, issue held off; strobe stays up until send lowers it
	task load(input logic [2:0] idx, input logic [63:0] d);
		issue_valid = 1'b0;
		load_valid = 1'b1;
		load_index = idx;
		load_data = d;
		@(negedge clk);
	endtask
endmodule
`default_nettype wire

/* File: tb/tb_packed_shift_subtract_unit.sv */
// Self-checking bench for the packed shift and subtract unit
`timescale 1ns/100ps
`default_nettype none
`include "pssu_defines.svh"
module tb_packed_shift_subtract_unit;
	logic clk;
	logic rst_n;
	wire logic issue_valid;
	wire logic [15:0] opcode;
	wire logic [7:0] modrm;
	wire logic [7:0] imm_byte;
	wire logic [63:0] mem_data;
	wire logic load_valid;
	wire logic [2:0] load_index;
	wire logic [63:0] load_data;
	logic result_valid;
	logic [2:0] result_index;
	logic [63:0] result_data;
	logic fault;
	int err_total;
	int checked;
	logic [31:0] seed;
	logic [63:0] v;
	logic [63:0] bank [8];
	localparam logic [15:0] OPS [10] = '{`OPC_WORD_ARS, `OPC_DWORD_LRS,
		`OPC_QWORD_LRS, `OPC_WORD_LRS, `OPC_BYTE_WSUB, `OPC_DWORD_WSUB,
		`OPC_SBYTE_SSUB, `OPC_SWORD_SSUB, `OPC_UBYTE_SSUB, `OPC_UWORD_SSUB};
	localparam int CNTS [10] = '{0, 1, 7, 15, 16, 31, 32, 63, 64, 255};
	// Saturation corners: minuend and subtrahend pairs
	localparam logic [63:0] SAT_D [2] = '{64'h8000_7FFF_0080_7F7F,
		64'h7F00_0080_7FFF_8000};
	localparam logic [63:0] SAT_S [2] = '{64'h0001_8000_7F01_81FF,
		64'h8101_7F01_8000_0001};

	decode_model dm_u (.clk(clk), .issue_valid(issue_valid),
		.opcode(opcode), .modrm(modrm), .imm_byte(imm_byte),
		.mem_data(mem_data), .load_valid(load_valid),
		.load_index(load_index), .load_data(load_data));

	packed_shift_subtract_unit dut_u (.clk(clk), .rst_n(rst_n),
		.issue_valid(issue_valid), .opcode(opcode), .modrm(modrm),
		.imm_byte(imm_byte), .mem_data(mem_data), .load_valid(load_valid),
		.load_index(load_index), .load_data(load_data),
		.result_valid(result_valid), .result_index(result_index),
		.result_data(result_data), .fault(fault));

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Random source
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C1_1DB7 : 32'h0);
	endfunction

	function automatic logic [63:0] rnd();
		seed = lfsr(seed);
		rnd[31:0] = seed;
		seed = lfsr(seed);
		rnd[63:32] = seed;
	endfunction

	// Lane model of every operation
	function automatic logic [63:0] calc(input int k, input logic [63:0] d,
		input logic [63:0] s);
		logic [63:0] r;
		logic [63:0] m;
		logic [63:0] dv;
		logic [63:0] sv;
		longint a;
		longint b;
		longint x;
		longint lim;
		int w;
		r = 64'h0;
		w = (k == 0 || k == 3 || k == 7 || k == 9) ? 16 :
			(k == 1 || k == 5) ? 32 : (k == 2) ? 64 : 8;
		m = (w == 64) ? '1 : (64'h1 << w) - 64'h1;
		lim = longint'(1) << (w - 1);
		for (int i = 0; i < 64 / w; i++) begin
			dv = (d >> (i * w)) & m;
			sv = (s >> (i * w)) & m;
			a = longint'(dv);
			b = longint'(sv);
			if (dv[w - 1] && (k == 0 || k == 6 || k == 7)) a = a - 2 * lim;
			if (sv[w - 1] && (k == 6 || k == 7)) b = b - 2 * lim;
			x = a - b;
			case (k)
			0: dv = (s >= w) ? (dv[w - 1] ? m : 64'h0) : 64'(a >>> s[5:0]) & m;
			1, 2, 3: dv = (s >= w) ? 64'h0 : dv >> s[5:0];
			4, 5: dv = 64'(x) & m;
			6, 7: dv = 64'((x >= lim) ? lim - 1 : (x < -lim) ? -lim : x) & m;
			default: dv = (x < 0) ? 64'h0 : 64'(x);
			endcase
			r = r | (dv << (i * w));
		end
		return r;
	endfunction

	task chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, exp, seen);
		end
	endtask

	// Form 0 register, 1 memory, 2 immediate count
	task do_op(input int k, input int form, input logic [2:0] ra,
		input logic [2:0] rb, input logic [63:0] cnt);
		logic [15:0] op;
		logic [7:0] mr;
		logic [63:0] s;
		logic [63:0] e;
		op = OPS[k];
		mr = {`MOD_REG_FORM, ra, rb};
		s = bank[rb];
		if (form == 1) begin
			mr[7:6] = 2'h0;
			s = cnt;
		end
		if (form == 2) begin
			op = (k == 1) ? `OPC_IMM_DWORD : (k == 2) ? `OPC_IMM_QWORD :
				`OPC_IMM_WORD;
			mr = {`MOD_REG_FORM,
				(k == 0) ? `GRP_ARITH_RIGHT : `GRP_LOGIC_RIGHT, ra};
			s = {56'h0, cnt[7:0]};
		end
		e = calc(k, bank[ra], s);
		dm_u.send(op, mr, cnt[7:0], cnt);
		@(posedge clk);
		@(negedge clk);
		chk("result_valid", {63'h0, result_valid}, 64'h1);
		chk("result_index", {61'h0, result_index}, {61'h0, ra});
		chk("result_data", result_data, e);
		bank[ra] = e;
	endtask

	// Unsupported encoding: fault pulse and no write
	task bad(input logic [15:0] op, input logic [7:0] mr);
		dm_u.send(op, mr, 8'h03, rnd());
		@(posedge clk);
		@(negedge clk);
		chk("fault", {63'h0, fault}, 64'h1);
		chk("refused valid", {63'h0, result_valid}, 64'h0);
	endtask

	task finish_test();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		$display("watchdog expired");
		err_total++;
		finish_test();
	end

	// Main sequence
	initial begin
		err_total = 0;
		checked = 0;
		seed = 32'h2b12;
		rst_n = 1'b0;
		foreach (bank[i]) bank[i] = 64'h0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		chk("reset data", result_data, 64'h0);
		chk("reset valid", {63'h0, result_valid}, 64'h0);
		for (int i = 0; i < 8; i++) begin
			v = rnd();
			dm_u.load(i[2:0], v);
			bank[i] = v;
		end
		$display("test reset and load done");
		for (int k = 0; k < 10; k++) begin
			v = rnd();
			dm_u.load(3'h7, {57'h0, v[6:0]});
			bank[7] = {57'h0, v[6:0]};
			do_op(k, 0, v[10:8], 3'h7, 64'h0);
			do_op(k, 0, v[13:11], v[16:14], 64'h0);
		end
		$display("test register forms done");
		for (int k = 0; k < 10; k++) begin
			v = rnd();
			do_op(k, 1, v[2:0], v[5:3], k < 4 ? {57'h0, v[12:6]} : rnd());
		end
		$display("test memory forms done");
		for (int k = 0; k < 4; k++) begin
			for (int j = 0; j < 10; j++) begin
				v = rnd();
				do_op(k, 2, v[2:0], 3'h0, 64'(CNTS[j]));
			end
		end
		$display("test immediate forms done");
		for (int j = 0; j < 2; j++) begin
			for (int k = 4; k < 10; k++) begin
				dm_u.load(3'h2, SAT_D[j]);
				bank[2] = SAT_D[j];
				dm_u.load(3'h3, SAT_S[j]);
				bank[3] = SAT_S[j];
				do_op(k, 0, 3'h2, 3'h3, 64'h0);
			end
		end
		$display("test saturation bounds done");
		bad(16'h0F71, 8'hF1);
		bad(16'h0F72, 8'hE2);
		bad(16'h0F73, 8'h13);
		bad(16'h0FE2, 8'hC1);
		do_op(5, 0, 3'h6, 3'h5, 64'h0);
		dm_u.idle();
		@(negedge clk);
		chk("valid pulse", {63'h0, result_valid}, 64'h0);
		$display("test refused encodings done");
		// Mid-run reset clears outputs and bank
		rst_n = 1'b0;
		@(negedge clk);
		rst_n = 1'b1;
		chk("mid reset data", result_data, 64'h0);
		chk("mid reset index", {61'h0, result_index}, 64'h0);
		foreach (bank[i]) bank[i] = 64'h0;
		do_op(4, 0, 3'h1, 3'h6, 64'h0);
		$display("test mid-run reset done");
		finish_test();
	end
endmodule
`default_nettype wire
